// ---- logic/mse_pkg.sv ----
// Package: opcodes, flag layout, widths and reset values for the instruction subset executor
package mse_pkg;
   localparam int DATA_W = 8;
   localparam int PADDR_W = 12;
   localparam int DADDR_W = 8;
   localparam int PWORD_W = 16;
   // Flag vector bit positions
   localparam int FLG_BORROW_INV = 0;
   localparam int FLG_NULL = 1;
   localparam int FLG_NIBBLE_BORROW = 2;
   localparam int FLG_SIGNED_WRAP = 3;
   localparam int FLAGS_W = 4;
   localparam logic [FLAGS_W-1:0] FLAGS_RST = 4'h0;
   localparam logic [DATA_W-1:0] WREG_RST = 8'h00;
   localparam logic [DATA_W-1:0] TBLHI_RST = 8'h00;
   localparam logic [DATA_W-1:0] ZERO_BYTE = 8'h00;
   // Page split of the program address: low byte indexes within a page
   localparam int PAGE_LSB_W = 8;
   localparam logic [PADDR_W-PAGE_LSB_W-1:0] LAST_PAGE = 4'hf;

   typedef enum logic [3:0] {
      MSE_OP_NOP = 4'h0,
      MSE_OP_SUB_IMM = 4'h1,
      MSE_OP_SWAP_MEM = 4'h2,
      MSE_OP_SWAP_WREG = 4'h3,
      MSE_OP_ZERO_SKIP = 4'h4,
      MSE_OP_ZERO_COPY_SKIP = 4'h5,
      MSE_OP_BIT_ZERO_SKIP = 4'h6,
      MSE_OP_TBL_CUR = 4'h7,
      MSE_OP_TBL_LAST = 4'h8,
      MSE_OP_XOR_MEM = 4'h9,
      MSE_OP_XOR_INTO_MEM = 4'ha,
      MSE_OP_XOR_IMM = 4'hb
   } mse_op_t;

   typedef struct packed {
      mse_op_t op;
      logic [DATA_W-1:0] imm;
      logic [DADDR_W-1:0] addr;
      logic [2:0] bit_sel;
   } mse_instr_t;

   typedef struct packed {
      logic we;
      logic [DADDR_W-1:0] addr;
      logic [DATA_W-1:0] data;
   } mse_dwr_t;

   typedef enum logic [1:0] {
      MSE_ST_IDLE = 2'b00,
      MSE_ST_TBL_WAIT = 2'b01,
      MSE_ST_SKIP = 2'b10
   } mse_state_t;
endpackage : mse_pkg

// ---- logic/mse_alu.sv ----
// Combinational datapath: subtract, swap, xor and zero detect
module mse_alu (
   input wire mse_pkg::mse_op_t i_op,
   input wire logic [mse_pkg::DATA_W-1:0] i_wreg,
   input wire logic [mse_pkg::DATA_W-1:0] i_mem,
   input wire logic [mse_pkg::DATA_W-1:0] i_imm,
   output logic [mse_pkg::DATA_W-1:0] o_result,
   output logic o_borrow_inv,
   output logic o_nibble_borrow,
   output logic o_signed_wrap,
   output logic o_null
);
   import mse_pkg::*;
   logic [DATA_W:0] diff;
   logic [4:0] ndiff;

   always_comb begin
      diff = {1'b0, i_wreg} - {1'b0, i_imm};
      ndiff = {1'b0, i_wreg[3:0]} - {1'b0, i_imm[3:0]};
      case (i_op)
         MSE_OP_SUB_IMM: o_result = diff[DATA_W-1:0];
         MSE_OP_SWAP_MEM: o_result = {i_mem[3:0], i_mem[7:4]};
         MSE_OP_SWAP_WREG: o_result = {i_mem[3:0], i_mem[7:4]};
         MSE_OP_XOR_MEM: o_result = i_wreg ^ i_mem;
         MSE_OP_XOR_INTO_MEM: o_result = i_wreg ^ i_mem;
         MSE_OP_XOR_IMM: o_result = i_wreg ^ i_imm;
         default: o_result = i_mem;
      endcase
      o_borrow_inv = ~diff[DATA_W];
      o_nibble_borrow = ~ndiff[4];
      // Signed overflow: operands differ in sign and result sign differs from minuend
      o_signed_wrap = (i_wreg[DATA_W-1] ^ i_imm[DATA_W-1]) & (i_wreg[DATA_W-1] ^ diff[DATA_W-1]);
      o_null = (o_result == ZERO_BYTE);
   end
endmodule : mse_alu

// ---- logic/mse_exec.sv ----
// Executor for the subtract/swap/skip/table-read/xor instruction subset
// Functional notes
// - Subtract immediate from working register, update flags
// - Borrow-inverse flag clear on negative, else set
// - Swap nibbles of memory byte in place
// - Swapped memory byte loads working register
// - Skip next when memory byte is zero
// - Copy byte to working register, skip if zero
// - Skip next when selected bit is zero
// - Table read current page: low to memory, high latched
// - Table read from last program page
// - Working register gets register xor memory
// - Memory byte gets register xor memory
// - Working register gets register xor immediate
// - Taken skip adds one dummy cycle
module mse_exec (
   input wire logic i_clk,
   input wire logic i_rst_b,
   input wire logic i_instr_valid,
   input wire mse_pkg::mse_instr_t i_instr,
   input wire logic [mse_pkg::PADDR_W-1:0] i_pc,
   input wire logic [mse_pkg::DATA_W-1:0] i_mem_rdata,
   input wire logic [mse_pkg::PWORD_W-1:0] i_prog_rdata,
   output logic o_busy,
   output logic o_skip_taken,
   output logic o_dummy_cycle,
   output logic [mse_pkg::DADDR_W-1:0] o_mem_raddr,
   output mse_pkg::mse_dwr_t o_mem_wr,
   output logic o_prog_re,
   output logic [mse_pkg::PADDR_W-1:0] o_prog_addr,
   output logic [mse_pkg::DATA_W-1:0] o_working_register,
   output logic [mse_pkg::DATA_W-1:0] o_table_high_latch,
   output logic [mse_pkg::FLAGS_W-1:0] o_flags
);
   import mse_pkg::*;

   mse_state_t state_r;
   mse_state_t state_nxt;
   logic [DATA_W-1:0] wreg_r;
   logic [DATA_W-1:0] tblhi_r;
   logic [FLAGS_W-1:0] flags_r;
   logic [DADDR_W-1:0] tbl_dest_r;
   mse_dwr_t wr_r;
   logic skip_r;
   logic [DATA_W-1:0] alu_res;
   logic alu_binv;
   logic alu_nb;
   logic alu_sw;
   logic alu_null;
   logic go;
   logic skip_cond;

   // Instructions are accepted only while idle; fetch must hold off on busy
   assign go = i_instr_valid && (state_r == MSE_ST_IDLE);
   assign o_busy = (state_r != MSE_ST_IDLE);
   // Memory byte is read combinationally from the instruction address
   assign o_mem_raddr = i_instr.addr;

   mse_alu u_alu (
      .i_op(i_instr.op),
      .i_wreg(wreg_r),
      .i_mem(i_mem_rdata),
      .i_imm(i_instr.imm),
      .o_result(alu_res),
      .o_borrow_inv(alu_binv),
      .o_nibble_borrow(alu_nb),
      .o_signed_wrap(alu_sw),
      .o_null(alu_null)
   );

   always_comb begin
      case (i_instr.op)
         MSE_OP_ZERO_SKIP: skip_cond = (i_mem_rdata == ZERO_BYTE);
         MSE_OP_ZERO_COPY_SKIP: skip_cond = (i_mem_rdata == ZERO_BYTE);
         MSE_OP_BIT_ZERO_SKIP: skip_cond = ~i_mem_rdata[i_instr.bit_sel];
         default: skip_cond = 1'b0;
      endcase
   end

   // Program address for table reads, registered so the memory sees a stable address
   always_ff @(posedge i_clk or negedge i_rst_b) begin
      if (!i_rst_b) begin
         o_prog_addr <= '0;
         o_prog_re <= 1'b0;
      end else if (go && i_instr.op == MSE_OP_TBL_CUR) begin
         o_prog_addr <= {i_pc[PADDR_W-1:PAGE_LSB_W], wreg_r};
         o_prog_re <= 1'b1;
      end else if (go && i_instr.op == MSE_OP_TBL_LAST) begin
         o_prog_addr <= {LAST_PAGE, wreg_r};
         o_prog_re <= 1'b1;
      end else begin
         o_prog_re <= 1'b0;
      end
   end

   always_comb begin
      state_nxt = state_r;
      case (state_r)
         MSE_ST_IDLE: begin
            if (go && (i_instr.op == MSE_OP_TBL_CUR || i_instr.op == MSE_OP_TBL_LAST)) begin
               state_nxt = MSE_ST_TBL_WAIT;
            end else if (go && skip_cond) begin
               state_nxt = MSE_ST_SKIP;
            end
         end
         MSE_ST_TBL_WAIT: state_nxt = MSE_ST_IDLE;
         MSE_ST_SKIP: state_nxt = MSE_ST_IDLE;
         default: state_nxt = MSE_ST_IDLE;
      endcase
   end

   always_ff @(posedge i_clk or negedge i_rst_b) begin
      if (!i_rst_b) begin
         state_r <= MSE_ST_IDLE;
      end else begin
         state_r <= state_nxt;
      end
   end

   // Skip strobe and the dummy cycle, asserted together in the cycle after a taken skip
   always_ff @(posedge i_clk or negedge i_rst_b) begin
      if (!i_rst_b) begin
         skip_r <= 1'b0;
      end else begin
         skip_r <= go && skip_cond;
      end
   end
   assign o_skip_taken = skip_r;
   assign o_dummy_cycle = (state_r == MSE_ST_SKIP);

   always_ff @(posedge i_clk or negedge i_rst_b) begin
      if (!i_rst_b) begin
         wreg_r <= WREG_RST;
      end else if (go) begin
         case (i_instr.op)
            MSE_OP_SUB_IMM: wreg_r <= alu_res;
            MSE_OP_SWAP_WREG: wreg_r <= alu_res;
            MSE_OP_ZERO_COPY_SKIP: wreg_r <= i_mem_rdata;
            MSE_OP_XOR_MEM: wreg_r <= alu_res;
            MSE_OP_XOR_IMM: wreg_r <= alu_res;
            default: wreg_r <= wreg_r;
         endcase
      end
   end

   // Swaps, skips and table reads leave every flag alone
   always_ff @(posedge i_clk or negedge i_rst_b) begin
      if (!i_rst_b) begin
         flags_r <= FLAGS_RST;
      end else if (go) begin
         case (i_instr.op)
            MSE_OP_SUB_IMM: begin
               flags_r[FLG_BORROW_INV] <= alu_binv;
               flags_r[FLG_NULL] <= alu_null;
               flags_r[FLG_NIBBLE_BORROW] <= alu_nb;
               flags_r[FLG_SIGNED_WRAP] <= alu_sw;
            end
            MSE_OP_XOR_MEM, MSE_OP_XOR_INTO_MEM, MSE_OP_XOR_IMM: begin
               flags_r[FLG_NULL] <= alu_null;
            end
            default: flags_r <= flags_r;
         endcase
      end
   end

   always_ff @(posedge i_clk or negedge i_rst_b) begin
      if (!i_rst_b) begin
         tbl_dest_r <= '0;
      end else if (go) begin
         tbl_dest_r <= i_instr.addr;
      end
   end

   always_ff @(posedge i_clk or negedge i_rst_b) begin
      if (!i_rst_b) begin
         tblhi_r <= TBLHI_RST;
      end else if (state_r == MSE_ST_TBL_WAIT) begin
         tblhi_r <= i_prog_rdata[PWORD_W-1:DATA_W];
      end
   end

   // Data memory write port, one registered write per memory swap, memory xor or table read
   always_ff @(posedge i_clk or negedge i_rst_b) begin
      if (!i_rst_b) begin
         wr_r <= '0;
      end else if (state_r == MSE_ST_TBL_WAIT) begin
         wr_r <= '{we: 1'b1, addr: tbl_dest_r, data: i_prog_rdata[DATA_W-1:0]};
      end else if (go && i_instr.op == MSE_OP_SWAP_MEM) begin
         wr_r <= '{we: 1'b1, addr: i_instr.addr, data: alu_res};
      end else if (go && i_instr.op == MSE_OP_XOR_INTO_MEM) begin
         wr_r <= '{we: 1'b1, addr: i_instr.addr, data: alu_res};
      end else begin
         wr_r <= '{we: 1'b0, addr: wr_r.addr, data: wr_r.data};
      end
   end

   assign o_mem_wr = wr_r;
   assign o_working_register = wreg_r;
   assign o_table_high_latch = tblhi_r;
   assign o_flags = flags_r;
endmodule : mse_exec

// ---- sim/mse_exec_props.sv ----
// Checker: results and timing of the executed instruction subset
module mse_exec_props import mse_pkg::*; (
   input wire logic i_clk,
   input wire logic i_rst_b,
   input wire logic i_instr_valid,
   input wire mse_pkg::mse_instr_t i_instr,
   input wire logic [11:0] i_pc,
   input wire logic [7:0] i_mem_rdata,
   input wire logic [15:0] i_prog_rdata,
   input wire logic o_busy,
   input wire logic o_skip_taken,
   input wire logic o_dummy_cycle,
   input wire mse_pkg::mse_dwr_t o_mem_wr,
   input wire logic o_prog_re,
   input wire logic [11:0] o_prog_addr,
   input wire logic [7:0] o_working_register,
   input wire logic [7:0] o_table_high_latch,
   input wire logic [3:0] o_flags
);
   timeunit 1ns;
   timeprecision 1ns;
   logic [3:0] op;
   logic [7:0] wr;
   logic [7:0] md;
   logic [7:0] sw;
   logic bv;
   // Valid while busy is ignored, so only accepted ops count
   assign op = (i_instr_valid && !o_busy) ? i_instr.op : MSE_OP_NOP;
   assign wr = o_working_register;
   assign md = i_mem_rdata;
   assign sw = {i_mem_rdata[3:0], i_mem_rdata[7:4]};
   assign bv = i_mem_rdata[i_instr.bit_sel];
   default clocking cb @(posedge i_clk); endclocking
   default disable iff (!i_rst_b);
   property p_sub;
      op == MSE_OP_SUB_IMM |=> wr == $past(wr) - $past(i_instr.imm)
         && o_flags[0] == ($past(wr) >= $past(i_instr.imm));
   endproperty
   a_sub: assert property (p_sub) else $error("subtract result wrong");
   property p_swap;
      op == MSE_OP_SWAP_MEM |=> o_mem_wr.we && o_mem_wr.data == $past(sw) && $stable(o_flags);
   endproperty
   a_swap: assert property (p_swap) else $error("swap write wrong");
   property p_swapw;
      op == MSE_OP_SWAP_WREG |=> wr == $past(sw) && $stable(o_flags);
   endproperty
   a_swapw: assert property (p_swapw) else $error("swap load wrong");
   property p_skip;
      op == MSE_OP_ZERO_SKIP && md == 8'h00 |=> o_skip_taken && o_dummy_cycle ##1 !o_busy;
   endproperty
   a_skip: assert property (p_skip) else $error("zero skip wrong");
   property p_copy;
      op == MSE_OP_ZERO_COPY_SKIP |=> wr == $past(md) && o_skip_taken == ($past(md) == 8'h00);
   endproperty
   a_copy: assert property (p_copy) else $error("copy skip wrong");
   property p_bit;
      op == MSE_OP_BIT_ZERO_SKIP |=> o_skip_taken == !$past(bv);
   endproperty
   a_bit: assert property (p_bit) else $error("bit skip wrong");
   property p_tbl;
      op == MSE_OP_TBL_CUR |=> o_prog_re && o_prog_addr[11:8] == $past(i_pc[11:8])
         ##1 o_table_high_latch == $past(i_prog_rdata[15:8]) && o_mem_wr.we
         && o_mem_wr.data == $past(i_prog_rdata[7:0]) && o_mem_wr.addr == $past(i_instr.addr, 2)
         && $stable(o_flags);
   endproperty
   a_tbl: assert property (p_tbl) else $error("table read wrong");
   property p_last;
      op == MSE_OP_TBL_LAST |=> o_prog_re && o_prog_addr[11:8] == LAST_PAGE
         ##1 o_table_high_latch == $past(i_prog_rdata[15:8]) && o_mem_wr.we
         && o_mem_wr.data == $past(i_prog_rdata[7:0]) && $stable(o_flags);
   endproperty
   a_last: assert property (p_last) else $error("last page wrong");
   property p_xor;
      op == MSE_OP_XOR_MEM |=> wr == ($past(wr) ^ $past(md)) && o_flags[1] == (wr == 8'h00);
   endproperty
   a_xor: assert property (p_xor) else $error("xor load wrong");
   property p_xor_into_memory;
      op == MSE_OP_XOR_INTO_MEM |=> o_mem_wr.data == ($past(wr) ^ $past(md))
         && o_mem_wr.we && $stable(o_flags[0]) && o_flags[1] == (o_mem_wr.data == 8'h00);
   endproperty
   a_xor_into_memory: assert property (p_xor_into_memory) else $error("xor store wrong");
   c_skip: cover property (o_skip_taken);
   c_tbl: cover property (op == MSE_OP_TBL_LAST);
   c_xor_into_memory: cover property (op == MSE_OP_XOR_INTO_MEM);
endmodule : mse_exec_props

bind mse_exec mse_exec_props u_props (.i_clk, .i_rst_b, .i_instr_valid, .i_instr, .i_pc,
   .i_mem_rdata, .i_prog_rdata, .o_busy, .o_skip_taken, .o_dummy_cycle, .o_mem_wr,
   .o_prog_re, .o_prog_addr, .o_working_register, .o_table_high_latch, .o_flags);

// ---- sim/mse_mem_model.sv ----
// Data memory and program memory seen by the executor
module mse_mem_model (
   input wire logic i_clk,
   input wire logic [7:0] i_mem_raddr,
   input wire mse_pkg::mse_dwr_t i_mem_wr,
   input wire logic i_prog_re,
   input wire logic [11:0] i_prog_addr,
   output logic [7:0] o_mem_rdata,
   output logic [15:0] o_prog_rdata
);
   timeunit 1ns;
   timeprecision 1ns;
   logic [7:0] mem [256];
   initial foreach (mem[i]) mem[i] = 8'h00;
   assign o_mem_rdata = mem[i_mem_raddr];
   // Word carries its address; outside a read it shows the inverse, not a stale word
   assign o_prog_rdata = i_prog_re ? {4'ha, i_prog_addr} : ~{4'ha, i_prog_addr};
   always @(posedge i_clk) begin
      if (i_mem_wr.we) begin
         mem[i_mem_wr.addr] <= i_mem_wr.data;
      end
   end
endmodule : mse_mem_model

// ---- sim/tb_mse_exec.sv ----
// Bench for the instruction subset executor
`define CHK(a, e) begin checked++; if ((a) !== (e)) begin bad_count++; \
   $display("[ERR] %0t %h %h", $time, a, e); end end
module tb_mse_exec import mse_pkg::*; ;
   timeunit 1ns;
   timeprecision 1ns;
   logic i_clk = 1'b0;
   logic i_rst_b = 1'b0;
   logic vld = 1'b0;
   mse_instr_t ins = '0;
   logic [11:0] pc = 12'h5a3;
   logic [7:0] mrd, mra, wreg, thl;
   logic [15:0] prd;
   logic [11:0] pad;
   logic [3:0] flg;
   logic busy, skp, dum, pre;
   mse_dwr_t mwr;
   int bad_count = 0;
   int checked = 0;
   int cyc = 0;
   always #25 i_clk = ~i_clk;
   mse_exec u_mse_exec (.i_clk(i_clk), .i_rst_b(i_rst_b), .i_instr_valid(vld), .i_instr(ins),
      .i_pc(pc), .i_mem_rdata(mrd), .i_prog_rdata(prd), .o_busy(busy), .o_skip_taken(skp),
      .o_dummy_cycle(dum), .o_mem_raddr(mra), .o_mem_wr(mwr), .o_prog_re(pre),
      .o_prog_addr(pad), .o_working_register(wreg), .o_table_high_latch(thl), .o_flags(flg));
   mse_mem_model u_mse_mem_model (.i_clk(i_clk), .i_mem_raddr(mra), .i_mem_wr(mwr),
      .i_prog_re(pre), .i_prog_addr(pad), .o_mem_rdata(mrd), .o_prog_rdata(prd));
   task automatic finish_test();
      $display("checks %0d errors %0d", checked, bad_count);
      if (bad_count == 0 && checked > 0) begin
         $display("Finished cleanly");
      end else begin
         $display("Finished with errors");
      end
      $finish;
   endtask : finish_test
   always @(posedge i_clk) begin
      cyc++;
      if (cyc == 400) begin
         bad_count++;
         finish_test();
      end
   end
   // Outputs are looked at 1 ns after the accepting edge
   task automatic issue(input mse_op_t op, input logic [7:0] imm, a, input logic [2:0] b);
      @(posedge i_clk);
      vld <= 1'b1;
      ins <= {op, imm, a, b};
      @(posedge i_clk);
      vld <= 1'b0;
      #1;
   endtask : issue
   task automatic t_sub();
      issue(MSE_OP_XOR_IMM, 8'h35, 8'h00, 3'h0);
      `CHK({wreg, flg}, 12'h350)
      issue(MSE_OP_SUB_IMM, 8'h36, 8'h00, 3'h0);
      `CHK({wreg, flg}, 12'hff0)
      issue(MSE_OP_SUB_IMM, 8'hff, 8'h00, 3'h0);
      `CHK({wreg, flg}, 12'h007)
      issue(MSE_OP_XOR_IMM, 8'h80, 8'h00, 3'h0);
      `CHK({wreg, flg}, 12'h805)
      issue(MSE_OP_SUB_IMM, 8'h01, 8'h00, 3'h0);
      `CHK({wreg, flg}, 12'h7f9)
   endtask : t_sub
   task automatic sk(input mse_op_t op, input logic [7:0] a, input logic [2:0] b, input logic t);
      issue(op, 8'h00, a, b);
      `CHK({skp, dum, busy, flg}, {t, t, t, 4'h9})
   endtask : sk
   task automatic t_skip();
      sk(MSE_OP_ZERO_SKIP, 8'h01, 3'h0, 1'b1);
      sk(MSE_OP_ZERO_SKIP, 8'h02, 3'h0, 1'b0);
      sk(MSE_OP_ZERO_COPY_SKIP, 8'h01, 3'h0, 1'b1);
      sk(MSE_OP_ZERO_COPY_SKIP, 8'h02, 3'h0, 1'b0);
      `CHK(wreg, 8'h01)
      sk(MSE_OP_BIT_ZERO_SKIP, 8'h03, 3'h2, 1'b1);
      sk(MSE_OP_BIT_ZERO_SKIP, 8'h03, 3'h3, 1'b0);
   endtask : t_skip
   task automatic t_swap();
      issue(MSE_OP_SWAP_MEM, 8'h00, 8'h04, 3'h0);
      `CHK({mwr, mra, flg}, {1'b1, 8'h04, 8'hc3, 8'h04, 4'h9})
      issue(MSE_OP_SWAP_WREG, 8'h00, 8'h04, 3'h0);
      `CHK({wreg, flg}, 12'h3c9)
   endtask : t_swap
   task automatic t_tbl();
      issue(MSE_OP_TBL_CUR, 8'h00, 8'h06, 3'h0);
      `CHK({pre, pad, busy}, {1'b1, 12'h53c, 1'b1})
      @(posedge i_clk);
      #1;
      `CHK({mwr, thl, busy}, {1'b1, 8'h06, 8'h3c, 8'ha5, 1'b0})
      issue(MSE_OP_TBL_LAST, 8'h00, 8'h07, 3'h0);
      `CHK({pre, pad}, {1'b1, 12'hf3c})
      @(posedge i_clk);
      #1;
      `CHK({mwr, thl, flg}, {1'b1, 8'h07, 8'h3c, 8'haf, 4'h9})
   endtask : t_tbl
   task automatic t_xor();
      issue(MSE_OP_XOR_MEM, 8'h00, 8'h05, 3'h0);
      `CHK({wreg, flg}, 12'h00b)
      issue(MSE_OP_XOR_INTO_MEM, 8'h00, 8'h05, 3'h0);
      `CHK({mwr, wreg, flg}, {1'b1, 8'h05, 8'h3c, 8'h00, 4'h9})
   endtask : t_xor
   // Reset in mid-run must clear the working register, table high latch, flags and busy, then work resumes at once
   task automatic t_reset();
      issue(MSE_OP_XOR_IMM, 8'h5a, 8'h00, 3'h0);
      `CHK({wreg, flg}, 12'h5a9)
      @(posedge i_clk);
      i_rst_b <= 1'b0;
      repeat (2) @(posedge i_clk);
      i_rst_b <= 1'b1;
      #1;
      `CHK({wreg, thl, flg, busy}, {WREG_RST, TBLHI_RST, FLAGS_RST, 1'b0})
      issue(MSE_OP_SUB_IMM, 8'h01, 8'h00, 3'h0);
      `CHK({wreg, flg}, 12'hff0)
   endtask : t_reset
   initial begin
      repeat (12) @(posedge i_clk);
      `CHK({wreg, flg, busy}, {WREG_RST, FLAGS_RST, 1'b0})
      u_mse_mem_model.mem[2] = 8'h01;
      u_mse_mem_model.mem[3] = 8'hfb;
      u_mse_mem_model.mem[4] = 8'h3c;
      u_mse_mem_model.mem[5] = 8'h3c;
      i_rst_b <= 1'b1;
      t_sub();
      t_skip();
      t_swap();
      t_tbl();
      t_xor();
      t_reset();
      finish_test();
   end
endmodule : tb_mse_exec
